// File: logic/afl_pkg.sv
/*
 * afl_pkg: offsets, field positions and reset values for the fault
 * latch and report block. Assumes an 8-bit register port in the core
 * clock domain.
 */
package afl_pkg;
  localparam logic [7:0] CHAN_STATUS_OFS = 8'h70;
  localparam logic [7:0] GLOBAL_FAULT_OFS = 8'h71;
  localparam logic [7:0] PIN_MASK_OFS    = 8'h74;
  localparam logic [7:0] FAULT_CLEAR_OFS = 8'h78;
  localparam int         CLEAR_BIT       = 7;
  // channel fault field positions
  localparam int         LEFT_DC_BIT     = 3;
  localparam int         RIGHT_DC_BIT    = 2;
  localparam int         LEFT_OC_BIT     = 1;
  localparam int         RIGHT_OC_BIT    = 0;
  // global fault field positions
  localparam int         OTP_CRC_BIT     = 7;
  localparam int         COEF_FAIL_BIT   = 6;
  localparam int         CLK_FAULT_BIT   = 2;
  localparam int         OV_BIT          = 1;
  localparam int         UV_BIT          = 0;
  // pin mask field positions
  localparam int         MASK_CLK_BIT    = 4;
  localparam int         MASK_UV_BIT     = 3;
  localparam int         MASK_OV_BIT     = 2;
  localparam int         DC_MASK_BIT     = 1;
  localparam int         OC_MASK_BIT     = 0;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam int         NUM_COND        = 7;

  // raw fault conditions from the analog and digital monitors
  typedef struct packed {
    logic left_dc;
    logic right_dc;
    logic left_oc;
    logic right_oc;
    logic clk_err;
    logic ov;
    logic uv;
  } afl_cond_t;

  // register port
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afl_req_t;
endpackage

// File: logic/afl_sync.sv
/*
 * afl_sync: two flip-flop synchroniser for a vector of levels.
 * Assumes inputs are quasi-static levels from outside the clock domain.
 */
`timescale 1ns/1ps
module afl_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// File: logic/afl_fault_latch.sv
/*
 * afl_fault_latch: latches channel, clock and supply faults, reports
 * them on the active-low fault pin and tristates the power stage.
 * Assumes fault conditions and error strobes arrive as levels from
 * outside the core clock; register port is synchronous to clk.
 */
`timescale 1ns/1ps
module afl_fault_latch (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire afl_pkg::afl_cond_t cond,
  input  wire logic               otp_crc_err,
  input  wire logic               coef_write_err,
  input  wire afl_pkg::afl_req_t  req,
  output logic [7:0]              rdata,
  output logic                    fault_pin_b,
  output logic                    outputs_hiz
);
  import afl_pkg::*;

  afl_cond_t   cs;
  logic [1:0]  err_s;
  logic [3:0]  chan_q;
  logic [7:0]  glob_q;
  logic [7:0]  fault_pin_mask_reg_q;
  logic        ov_prev_q;
  logic        uv_prev_q;
  logic        otp_prev_q;
  logic        coef_prev_q;
  logic        clear;
  logic [3:0]  chan_set;
  logic [7:0]  glob_set;
  logic        report;
  logic        hiz_d;

  // all monitor levels cross into clk before any logic looks at them
  afl_sync #(.W(NUM_COND)) u_cond_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (cond),
    .dout  (cs)
  );
  afl_sync #(.W(2)) u_err_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({otp_crc_err, coef_write_err}),
    .dout  (err_s)
  );

  assign clear = req.wr && (req.addr == FAULT_CLEAR_OFS)
                 && req.wdata[CLEAR_BIT];

  always_comb begin
    chan_set = '0;
    chan_set[LEFT_DC_BIT]  = cs.left_dc;
    chan_set[RIGHT_DC_BIT] = cs.right_dc;
    chan_set[LEFT_OC_BIT]  = cs.left_oc;
    chan_set[RIGHT_OC_BIT] = cs.right_oc;
    glob_set = '0;
    glob_set[CLK_FAULT_BIT] = cs.clk_err;
    // supply flags set on onset only, so a clear holds while it persists
    glob_set[OV_BIT] = cs.ov && !ov_prev_q;
    glob_set[UV_BIT] = cs.uv && !uv_prev_q;
    glob_set[OTP_CRC_BIT]   = err_s[1] && !otp_prev_q;
    glob_set[COEF_FAIL_BIT] = err_s[0] && !coef_prev_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ov_prev_q   <= 1'b0;
      uv_prev_q   <= 1'b0;
      otp_prev_q  <= 1'b0;
      coef_prev_q <= 1'b0;
    end else begin
      ov_prev_q   <= cs.ov;
      uv_prev_q   <= cs.uv;
      otp_prev_q  <= err_s[1];
      coef_prev_q <= err_s[0];
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_q <= REG_RESET[3:0];
    end else begin
      chan_q <= (clear ? 4'h0 : chan_q) | chan_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      glob_q <= REG_RESET;
    end else begin
      glob_q <= (clear ? 8'h00 : glob_q) | glob_set;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_pin_mask_reg_q <= REG_RESET;
    end else if (req.wr && req.addr == PIN_MASK_OFS) begin
      fault_pin_mask_reg_q <= req.wdata;
    end
  end

  always_comb begin
    report =
      ((chan_q[LEFT_DC_BIT] | chan_q[RIGHT_DC_BIT])
        & ~fault_pin_mask_reg_q[DC_MASK_BIT])
      | ((chan_q[LEFT_OC_BIT] | chan_q[RIGHT_OC_BIT])
        & ~fault_pin_mask_reg_q[OC_MASK_BIT])
      | (glob_q[CLK_FAULT_BIT] & ~fault_pin_mask_reg_q[MASK_CLK_BIT])
      | (glob_q[OV_BIT] & ~fault_pin_mask_reg_q[MASK_OV_BIT])
      | (glob_q[UV_BIT] & ~fault_pin_mask_reg_q[MASK_UV_BIT]);
    // channel faults hold until cleared; supply and clock follow the
    // live condition, so they recover without host action
    hiz_d = (|chan_q) | (|chan_set) | cs.clk_err | cs.ov
            | cs.uv;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_pin_b <= 1'b1;
      outputs_hiz <= 1'b0;
    end else begin
      fault_pin_b <= !report;
      outputs_hiz <= hiz_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= REG_RESET;
    end else begin
      unique case (req.addr)
        CHAN_STATUS_OFS:  rdata <= {4'h0, chan_q};
        GLOBAL_FAULT_OFS: rdata <= glob_q;
        PIN_MASK_OFS:     rdata <= fault_pin_mask_reg_q;
        default:          rdata <= 8'h00;
      endcase
    end
  end

  left_dc_hiz_a: assert property (@(posedge clk) disable iff (!rst_b)
    cs.left_dc |-> ##1 chan_q[LEFT_DC_BIT] ##1 outputs_hiz)
    else $error("left dc fault not latched");
  right_dc_hiz_a: assert property (@(posedge clk) disable iff (!rst_b)
    cs.right_dc |-> ##1 chan_q[RIGHT_DC_BIT] ##1 outputs_hiz)
    else $error("right dc fault not latched");
  left_oc_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    cs.left_oc |=> chan_q[LEFT_OC_BIT] && outputs_hiz)
    else $error("left overcurrent not latched");
  right_oc_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    cs.right_oc |=> chan_q[RIGHT_OC_BIT] && outputs_hiz)
    else $error("right overcurrent not latched");
  flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (chan_q[LEFT_DC_BIT] && !clear) |=> chan_q[LEFT_DC_BIT])
    else $error("latched flag lost without clear");
  clear_flags_a: assert property (@(posedge clk) disable iff (!rst_b)
    (clear && chan_set == 4'h0 && glob_set == 8'h00)
    |=> (chan_q == 4'h0 && glob_q == 8'h00))
    else $error("flags not cleared by clear bit");
  clk_fault_a: assert property (@(posedge clk) disable iff (!rst_b)
    cs.clk_err |=> glob_q[CLK_FAULT_BIT] && outputs_hiz)
    else $error("clock fault not reported");
  clk_recover_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!cs.clk_err && !cs.ov && !cs.uv && chan_q == 4'h0
     && chan_set == 4'h0) |=> !outputs_hiz)
    else $error("no recovery after supply and clock ok");
  ov_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cs.ov) |=> glob_q[OV_BIT] && outputs_hiz)
    else $error("overvoltage not latched");
  ov_rearm_a: assert property (@(posedge clk) disable iff (!rst_b)
    (clear && $past(cs.ov) && cs.ov) |=> !glob_q[OV_BIT])
    else $error("overvoltage flag set again while persisting");
  uv_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(cs.uv) |=> glob_q[UV_BIT] && outputs_hiz)
    else $error("undervoltage not latched");
  uv_rearm_a: assert property (@(posedge clk) disable iff (!rst_b)
    (clear && $past(cs.uv) && cs.uv) |=> !glob_q[UV_BIT])
    else $error("undervoltage flag set again while persisting");
  otp_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(err_s[1]) |=> glob_q[OTP_CRC_BIT])
    else $error("memory integrity error not latched");
  coef_set_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(err_s[0]) |=> glob_q[COEF_FAIL_BIT])
    else $error("coefficient write error not latched");
  pin_report_a: assert property (@(posedge clk) disable iff (!rst_b)
    (chan_q[RIGHT_OC_BIT] && !fault_pin_mask_reg_q[OC_MASK_BIT])
    |=> !fault_pin_b)
    else $error("unmasked fault not on pin");
  pin_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    (chan_q == 4'h0 && glob_q[CLK_FAULT_BIT:UV_BIT] == 3'h0) |=> fault_pin_b)
    else $error("fault pin held with no flag");
  pin_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fault_pin_mask_reg_q == 8'h1f) |=> fault_pin_b)
    else $error("masked fault reached pin");
  dc_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    (fault_pin_mask_reg_q[DC_MASK_BIT] && !chan_q[LEFT_OC_BIT]
     && !chan_q[RIGHT_OC_BIT] && glob_q[CLK_FAULT_BIT:UV_BIT] == 3'h0)
    |=> fault_pin_b)
    else $error("masked dc fault reached pin");
  oc_hold_hiz_a: assert property (@(posedge clk) disable iff (!rst_b)
    (|chan_q) |=> outputs_hiz)
    else $error("outputs not hiz with channel fault");
endmodule

// File: testbench/afl_fault_latch_bench.sv
/*
 * afl_fault_latch_bench: self-checking bench for the fault latch and
 * report block. Assumes the package field map and the hand-over latency
 * (flag three edges after a condition, pin one edge later).
 */
`timescale 1ns/1ps
module afl_fault_latch_bench;
  import afl_pkg::*;
  logic       clk;
  logic       rst_b;
  afl_cond_t  cond;
  logic       otp_crc_err;
  logic       coef_write_err;
  afl_req_t   req;
  logic [7:0] rdata;
  logic       fault_pin_b;
  logic       outputs_hiz;
  int         n_fail;
  int         compares;
  int         ci[5] = '{4, 6, 1, 0, 2};

  afl_fault_latch dut_u (
    .clk            (clk),
    .rst_b          (rst_b),
    .cond           (cond),
    .otp_crc_err    (otp_crc_err),
    .coef_write_err (coef_write_err),
    .req            (req),
    .rdata          (rdata),
    .fault_pin_b    (fault_pin_b),
    .outputs_hiz    (outputs_hiz)
  );

  always #25 clk = ~clk;

  // sample 1 ns after the edge so that its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req.addr <= a;
    tick(2);
    chk(rdata, exp);
  endtask

  task automatic pins(input logic p, input logic h);
    chk({6'h0, fault_pin_b, outputs_hiz}, {6'h0, p, h});
  endtask

  // five edges covers sync, flag and pin
  task automatic setc(input int i, input logic v);
    @(posedge clk);
    cond[i] <= v;
    tick(5);
  endtask

  task automatic clear_all;
    wr(FAULT_CLEAR_OFS, 8'h80);
    tick(2);
  endtask

  task automatic t_reset;
    rd(CHAN_STATUS_OFS, 8'h00);
    rd(GLOBAL_FAULT_OFS, 8'h00);
    rd(PIN_MASK_OFS, 8'h00);
    pins(1'b1, 1'b0);
    wr(CHAN_STATUS_OFS, 8'hFF);
    wr(GLOBAL_FAULT_OFS, 8'hFF);
    rd(CHAN_STATUS_OFS, 8'h00);
    rd(GLOBAL_FAULT_OFS, 8'h00);
    rd(8'h55, 8'h00);
  endtask

  task automatic t_chan;
    for (int b = 0; b < 4; b++) begin
      setc(b + 3, 1'b1);
      rd(CHAN_STATUS_OFS, 8'h01 << b);
      pins(1'b0, 1'b1);
      setc(b + 3, 1'b0);
      rd(CHAN_STATUS_OFS, 8'h01 << b);
      pins(1'b0, 1'b1);
      clear_all();
      rd(CHAN_STATUS_OFS, 8'h00);
      pins(1'b1, 1'b0);
    end
  endtask

  task automatic t_auto;
    for (int b = 0; b < 3; b++) begin
      setc(b, 1'b1);
      rd(GLOBAL_FAULT_OFS, 8'h01 << b);
      pins(1'b0, 1'b1);
      setc(b, 1'b0);
      pins(1'b0, 1'b0);
      rd(GLOBAL_FAULT_OFS, 8'h01 << b);
      clear_all();
      rd(GLOBAL_FAULT_OFS, 8'h00);
      pins(1'b1, 1'b0);
    end
  endtask

  // supply flags must not come back while the fault merely persists
  task automatic t_rearm;
    for (int b = 0; b < 2; b++) begin
      setc(b, 1'b1);
      clear_all();
      rd(GLOBAL_FAULT_OFS, 8'h00);
      pins(1'b1, 1'b1);
      setc(b, 1'b0);
      setc(b, 1'b1);
      rd(GLOBAL_FAULT_OFS, 8'h01 << b);
      setc(b, 1'b0);
      clear_all();
    end
  endtask

  task automatic t_err;
    @(posedge clk);
    otp_crc_err <= 1'b1;
    tick(5);
    rd(GLOBAL_FAULT_OFS, 8'h80);
    @(posedge clk);
    coef_write_err <= 1'b1;
    tick(5);
    rd(GLOBAL_FAULT_OFS, 8'hC0);
    @(posedge clk);
    otp_crc_err <= 1'b0;
    coef_write_err <= 1'b0;
    tick(5);
    clear_all();
    rd(GLOBAL_FAULT_OFS, 8'h00);
  endtask

  task automatic t_mask;
    for (int i = 0; i < 5; i++) begin
      wr(PIN_MASK_OFS, 8'h01 << i);
      rd(PIN_MASK_OFS, 8'h01 << i);
      setc(ci[i], 1'b1);
      pins(1'b1, 1'b1);
      setc(ci[i], 1'b0);
      wr(PIN_MASK_OFS, 8'h00);
      tick(2);
      pins(1'b0, i < 2);
      clear_all();
    end
    // every class masked at once: a dc fault must stay off the pin
    wr(PIN_MASK_OFS, 8'h1f);
    rd(PIN_MASK_OFS, 8'h1f);
    setc(6, 1'b1);
    pins(1'b1, 1'b1);
    setc(6, 1'b0);
    wr(PIN_MASK_OFS, 8'h00);
    clear_all();
    pins(1'b1, 1'b0);
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    cond = '0;
    otp_crc_err = 1'b0;
    coef_write_err = 1'b0;
    req = '0;
    n_fail = 0;
    compares = 0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    t_reset();
    t_chan();
    t_auto();
    t_rearm();
    t_err();
    t_mask();
    print_verdict();
  end
endmodule
